// ===== hw/timer2_pkg.sv
// Constants, field positions and encodings shared by the timer2 waveform control block.
package timer2_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [2:0] OFF_CTRL  = 3'h0;
   localparam logic [2:0] OFF_CNT   = 3'h1;
   localparam logic [2:0] OFF_CMP   = 3'h2;
   localparam logic [2:0] OFF_FLAGS = 3'h3;
   localparam logic [2:0] OFF_CFG   = 3'h4;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_FORCE  = 7;
   localparam int BIT_WGM_LO = 6;
   localparam int BIT_COM_HI = 5;
   localparam int BIT_COM_LO = 4;
   localparam int BIT_WGM_HI = 3;
   localparam int BIT_CS_HI  = 2;
   localparam int FLAG_OVF   = 0;
   localparam int FLAG_CMP   = 1;
   localparam int CFG_DIR    = 0;
   localparam int CFG_ASYNC  = 1;

   // ---------------------------------------------------------------
   // Reset values and counter limits
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] CNT_RST   = 8'h00;
   localparam logic [7:0] CMP_RST   = 8'h00;
   localparam logic [1:0] FLAGS_RST = 2'h0;
   localparam logic [1:0] CFG_RST   = 2'h0;
   localparam logic [7:0] CNT_MAX   = 8'hFF;
   localparam logic [7:0] CNT_BOT   = 8'h00;

   // ---------------------------------------------------------------
   // Prescaler tap masks (divisor minus one)
   // ---------------------------------------------------------------
   localparam logic [9:0] DIV1_MASK    = 10'h000;
   localparam logic [9:0] DIV8_MASK    = 10'h007;
   localparam logic [9:0] DIV32_MASK   = 10'h01F;
   localparam logic [9:0] DIV64_MASK   = 10'h03F;
   localparam logic [9:0] DIV128_MASK  = 10'h07F;
   localparam logic [9:0] DIV256_MASK  = 10'h0FF;
   localparam logic [9:0] DIV1024_MASK = 10'h3FF;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_PCPWM  = 2'h1,
      MODE_CTC    = 2'h2,
      MODE_FAST   = 2'h3
   } mode_t;

   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;

   typedef enum logic [1:0] {
      DIR_UP   = 2'b01,
      DIR_DOWN = 2'b10
   } dir_t;

endpackage : timer2_pkg

// ===== hw/timer2_waveform_control.sv
// 8-bit timer/counter with one compare channel, prescaler and register port.
`timescale 1ns/1ps
module timer2_waveform_control
   import timer2_pkg::*;
(
   input  wire  logic       clk_sys,
   input  wire  logic       reset_n,
   input  wire  logic [2:0] regAddr,
   input  wire  logic [7:0] regWrData,
   input  wire  logic       regWr,
   input  wire  logic       regRd,
   output logic       [7:0] regRdData,
   input  wire  logic       oscPin,
   output logic             cmpPinOut,
   output logic             cmpPinOe,
   output logic             cmpOverride,
   output logic             cmpMatchFlag,
   output logic             overflowFlag
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0] ctrlQ,   ctrlD;
   logic [7:0] cntQ,    cntD;
   logic [7:0] ocrBufQ, ocrBufD;
   logic [7:0] ocrActQ, ocrActD;
   logic [1:0] flagsQ,  flagsD;
   logic [1:0] cfgQ,    cfgD;
   logic [9:0] prescQ,  prescD;
   logic       blockQ,  blockD;
   logic       ocOutQ,  ocOutD;
   logic       pinOeQ,  pinOeD;
   logic       ovrQ,    ovrD;
   logic [7:0] rdQ,     rdD;
   dir_t       dirQ,    dirD;
   logic       oscSync1Q;
   logic       oscSync2Q;
   logic       oscPrevQ;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   mode_t      mode;
   logic [1:0] com;
   logic [2:0] clkSel;
   logic       pwm;
   logic       srcTick;
   logic       tick;
   logic [9:0] divMask;
   logic       match;
   logic       ignoreMatch;
   logic       wrCtrl;
   logic       wrCnt;
   logic       forceHit;
   mode_t      newMode;
   logic [1:0] newCom;

   assign mode    = mode_t'({ctrlQ[BIT_WGM_HI], ctrlQ[BIT_WGM_LO]});
   assign com     = ctrlQ[BIT_COM_HI:BIT_COM_LO];
   assign clkSel  = ctrlQ[BIT_CS_HI:0];
   assign pwm     = (mode == MODE_PCPWM) || (mode == MODE_FAST);
   assign wrCtrl  = regWr && (regAddr == OFF_CTRL);
   assign wrCnt   = regWr && (regAddr == OFF_CNT);
   assign newMode = mode_t'({regWrData[BIT_WGM_HI], regWrData[BIT_WGM_LO]});
   assign newCom  = regWrData[BIT_COM_HI:BIT_COM_LO];

   // In async mode each synchronised oscillator rising edge is one source tick.
   assign srcTick = cfgQ[CFG_ASYNC] ? (oscSync2Q & ~oscPrevQ) : 1'b1;

   always_comb begin
      case (clkSel)
         3'h2:    divMask = DIV8_MASK;
         3'h3:    divMask = DIV32_MASK;
         3'h4:    divMask = DIV64_MASK;
         3'h5:    divMask = DIV128_MASK;
         3'h6:    divMask = DIV256_MASK;
         3'h7:    divMask = DIV1024_MASK;
         default: divMask = DIV1_MASK;
      endcase
   end

   assign tick        = srcTick && (clkSel != 3'h0) && ((prescQ & divMask) == divMask);
   assign match       = (cntQ == ocrActQ) && !blockQ;
   assign ignoreMatch = pwm && (ocrActQ == CNT_MAX) && com[1];
   assign forceHit    = wrCtrl && regWrData[BIT_FORCE] &&
                        (newMode == MODE_NORMAL || newMode == MODE_CTC);

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      ctrlD   = ctrlQ;
      cntD    = cntQ;
      ocrBufD = ocrBufQ;
      ocrActD = ocrActQ;
      flagsD  = flagsQ;
      cfgD    = cfgQ;
      blockD  = blockQ;
      ocOutD  = ocOutQ;
      dirD    = dirQ;
      rdD     = 8'h00;
      prescD  = srcTick ? 10'(prescQ + 10'h001) : prescQ;

      if (tick) begin
         blockD = 1'b0;
         if (match) begin
            flagsD[FLAG_CMP] = 1'b1;
         end
         case (mode)
            MODE_NORMAL: begin
               cntD = 8'(cntQ + 8'h01);
               if (cntQ == CNT_MAX) flagsD[FLAG_OVF] = 1'b1;
               if (match && com == COM_TOGGLE) ocOutD = ~ocOutQ;
               else if (match && com[1]) ocOutD = com[0];
            end
            MODE_CTC: begin
               cntD = match ? CNT_BOT : 8'(cntQ + 8'h01);
               if (cntQ == CNT_MAX) flagsD[FLAG_OVF] = 1'b1;
               if (match && com == COM_TOGGLE) ocOutD = ~ocOutQ;
               else if (match && com[1]) ocOutD = com[0];
            end
            MODE_FAST: begin
               cntD = 8'(cntQ + 8'h01);
               if (match && !ignoreMatch && com[1]) ocOutD = com[0];
               if (cntQ == CNT_MAX) begin
                  flagsD[FLAG_OVF] = 1'b1;
                  ocrActD = ocrBufQ;
                  if (com[1]) ocOutD = ~com[0];
               end
            end
            MODE_PCPWM: begin
               if (dirQ == DIR_UP) begin
                  if (match && !ignoreMatch && com[1]) ocOutD = com[0];
                  if (cntQ == CNT_MAX) begin
                     dirD    = DIR_DOWN;
                     cntD    = 8'(cntQ - 8'h01);
                     ocrActD = ocrBufQ;
                     if (ignoreMatch) ocOutD = ~com[0];
                  end else begin
                     cntD = 8'(cntQ + 8'h01);
                  end
               end else begin
                  if (match && !ignoreMatch && com[1]) ocOutD = ~com[0];
                  if (cntQ == CNT_BOT) begin
                     dirD = DIR_UP;
                     cntD = 8'(cntQ + 8'h01);
                     flagsD[FLAG_OVF] = 1'b1;
                  end else begin
                     cntD = 8'(cntQ - 8'h01);
                  end
               end
            end
            default: cntD = cntQ;
         endcase
      end

      if (mode != MODE_PCPWM) dirD = DIR_UP;

      // Forced compare changes only the output, never a flag or the counter.
      if (forceHit) begin
         if (newCom == COM_TOGGLE) ocOutD = ~ocOutQ;
         else if (newCom[1]) ocOutD = newCom[0];
      end

      if (regWr) begin
         case (regAddr)
            OFF_CTRL:  ctrlD = {1'b0, regWrData[BIT_WGM_LO:0]};
            OFF_CNT: begin
               cntD   = regWrData;
               blockD = 1'b1;
            end
            OFF_CMP:   ocrBufD = regWrData;
            // A flag newly set by hardware in this cycle survives a write-one clear.
            OFF_FLAGS: flagsD = (flagsD & ~flagsQ) | (flagsQ & ~regWrData[1:0]);
            OFF_CFG:   cfgD = regWrData[1:0];
            default:   cfgD = cfgD;
         endcase
      end

      // Non-PWM modes use the written compare value at once.
      if (ctrlD[BIT_WGM_LO] == 1'b0) ocrActD = ocrBufD;

      if (regRd) begin
         case (regAddr)
            OFF_CTRL:  rdD = ctrlQ;
            OFF_CNT:   rdD = cntQ;
            OFF_CMP:   rdD = ocrBufQ;
            OFF_FLAGS: rdD = {6'h00, flagsQ};
            OFF_CFG:   rdD = {6'h00, cfgQ};
            default:   rdD = 8'h00;
         endcase
      end

      ovrD   = (ctrlD[BIT_COM_HI:BIT_COM_LO] != COM_OFF);
      pinOeD = ovrD && cfgD[CFG_DIR];
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrlQ     <= CTRL_RST;
         cntQ      <= CNT_RST;
         ocrBufQ   <= CMP_RST;
         ocrActQ   <= CMP_RST;
         flagsQ    <= FLAGS_RST;
         cfgQ      <= CFG_RST;
         prescQ    <= 10'h000;
         blockQ    <= 1'b0;
         ocOutQ    <= 1'b0;
         pinOeQ    <= 1'b0;
         ovrQ      <= 1'b0;
         rdQ       <= 8'h00;
         dirQ      <= DIR_UP;
         oscSync1Q <= 1'b0;
         oscSync2Q <= 1'b0;
         oscPrevQ  <= 1'b0;
      end else begin
         ctrlQ     <= ctrlD;
         cntQ      <= cntD;
         ocrBufQ   <= ocrBufD;
         ocrActQ   <= ocrActD;
         flagsQ    <= flagsD;
         cfgQ      <= cfgD;
         prescQ    <= prescD;
         blockQ    <= blockD;
         ocOutQ    <= ocOutD;
         pinOeQ    <= pinOeD;
         ovrQ      <= ovrD;
         rdQ       <= rdD;
         dirQ      <= dirD;
         oscSync1Q <= oscPin;
         oscSync2Q <= oscSync1Q;
         oscPrevQ  <= oscSync2Q;
      end
   end

   assign regRdData    = rdQ;
   assign cmpPinOut    = ocOutQ;
   assign cmpPinOe     = pinOeQ;
   assign cmpOverride  = ovrQ;
   assign cmpMatchFlag = flagsQ[FLAG_CMP];
   assign overflowFlag = flagsQ[FLAG_OVF];

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_force_reads_zero: assert property (regRd && regAddr == OFF_CTRL |=> !regRdData[BIT_FORCE])
      else $error("force strobe bit read back as one");
   chk_force_no_flag: assert property (forceHit && !(tick && match) |=> !$rose(cmpMatchFlag))
      else $error("forced compare set the match flag");
   chk_blocked_match: assert property (tick && blockQ && !forceHit |=> !$rose(cmpMatchFlag))
      else $error("compare match not blocked after counter write");
   chk_stopped_hold: assert property (clkSel == 3'h0 && !wrCnt |=> cntQ == $past(cntQ))
      else $error("counter moved while stopped");
   chk_div8_spacing: assert property (tick && clkSel == 3'h2 && !cfgQ[CFG_ASYNC]
                                      |=> (!tick || clkSel != 3'h2)[*7])
      else $error("divide by 8 tick spacing wrong");
   chk_fast_wrap: assert property (mode == MODE_FAST && tick && cntQ == CNT_MAX && !wrCnt
                                   |=> cntQ == CNT_BOT && overflowFlag)
      else $error("fast PWM did not wrap to zero");
   chk_pc_turn: assert property (mode == MODE_PCPWM && tick && cntQ == CNT_MAX && dirQ == DIR_UP && !wrCnt
                                 && !wrCtrl |=> dirQ == DIR_DOWN && cntQ == 8'hFE)
      else $error("phase correct turn at MAX wrong");
   chk_pc_ovf_bottom: assert property (mode == MODE_PCPWM && tick && cntQ == CNT_BOT && dirQ == DIR_DOWN
                                       |=> overflowFlag)
      else $error("phase correct overflow not set at BOTTOM");
   chk_ctc_clear: assert property (mode == MODE_CTC && tick && match && !wrCnt
                                   |=> cntQ == CNT_BOT && cmpMatchFlag)
      else $error("clear on match did not clear counter");
   chk_pin_enable: assert property (cmpPinOe |-> cmpOverride && cfgQ[CFG_DIR])
      else $error("pin driven without override and direction");

   cov_fast_wrap: cover property (mode == MODE_FAST && tick && cntQ == CNT_MAX);
   cov_pc_turn: cover property (mode == MODE_PCPWM && tick && cntQ == CNT_MAX && dirQ == DIR_UP);
   cov_force: cover property (forceHit ##1 $changed(cmpPinOut));
   cov_ctc_clear: cover property (mode == MODE_CTC && tick && match);

endmodule : timer2_waveform_control

// ===== sim/tb_timer2_waveform_control.sv
// Self-checking testbench for the timer2 waveform control block.
`timescale 1ns/1ps
module tb_timer2_waveform_control;
   import timer2_pkg::*;

   logic       clk_sys;
   logic       reset_n;
   logic [2:0] regAddr;
   logic [7:0] regWrData;
   logic       regWr;
   logic       regRd;
   logic [7:0] regRdData;
   logic       oscPin;
   logic       cmpPinOut;
   logic       cmpPinOe;
   logic       cmpOverride;
   logic       cmpMatchFlag;
   logic       overflowFlag;
   logic [2:0] watch;
   logic [7:0] rd;
   logic [7:0] rdB;
   int         failCount = 0;
   int         nChecks   = 0;

   assign watch = {cmpPinOut, cmpMatchFlag, overflowFlag};

   timer2_waveform_control u_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .oscPin(oscPin),
      .cmpPinOut(cmpPinOut), .cmpPinOe(cmpPinOe), .cmpOverride(cmpOverride),
      .cmpMatchFlag(cmpMatchFlag), .overflowFlag(overflowFlag));

   // ---------------------------------------------------------------
   // Bus cycles, waits and comparison
   // ---------------------------------------------------------------
   task automatic wrap_up();
      if (failCount == 0 && nChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : idle

   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
      @(posedge clk_sys);
   endtask : reg_wr

   task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      d = regRdData;
      @(posedge clk_sys);
   endtask : reg_rd

   // Waits for bit sel of {pin, match flag, overflow flag} to reach val.
   task automatic wait_on(input int sel, input logic val, input int limit);
      for (int i = 0; i < limit; i++) begin
         idle(1);
         if (watch[sel] === val) return;
      end
      failCount++;
      $display("[FAIL] wait on signal %0d expected %b within %0d cycles", sel, val, limit);
      wrap_up();
   endtask : wait_on

   task automatic restart(input logic [7:0] cnt, input logic [7:0] cmp, input logic [7:0] ctl);
      // A forced clear in normal mode leaves the pin low before each scenario that calls restart.
      reg_wr(OFF_CTRL, 8'hA0);
      reg_wr(OFF_FLAGS, 8'h03);
      reg_wr(OFF_CMP, cmp);
      reg_wr(OFF_CNT, cnt);
      reg_wr(OFF_CTRL, ctl);
   endtask : restart

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      reg_rd(OFF_CTRL, rd);
      check("control reset", rd, 8'h00);
      reg_wr(3'h5, 8'hFF);
      reg_rd(3'h5, rd);
      check("unmapped read", rd, 8'h00);
      reg_wr(OFF_CMP, 8'hA5);
      reg_rd(OFF_CMP, rd);
      check("compare readback", rd, 8'hA5);
      reg_wr(OFF_CNT, 8'h3C);
      reg_rd(OFF_CNT, rd);
      check("counter readback", rd, 8'h3C);
   endtask : t_regs

   task automatic t_force();
      logic [7:0] ctl [6] = '{8'h90, 8'hA0, 8'hB0, 8'h98, 8'hF8, 8'hF0};
      logic [7:0] pin [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
      restart(8'h07, 8'h07, 8'h00);
      reg_wr(OFF_CFG, 8'h01);
      for (int i = 0; i < 6; i++) begin
         reg_wr(OFF_CTRL, ctl[i]);
         idle(1);
         check("forced pin", {7'h00, cmpPinOut}, pin[i]);
      end
      check("forced flag", {7'h00, cmpMatchFlag}, 8'h00);
      reg_rd(OFF_CTRL, rd);
      check("force bit read", rd, 8'h70);
      reg_rd(OFF_CNT, rd);
      check("forced no clear", rd, 8'h07);
      reg_wr(OFF_CFG, 8'h00);
      idle(1);
      check("override no drive", {6'h00, cmpOverride, cmpPinOe}, 8'h02);
      reg_wr(OFF_CFG, 8'h01);
      reg_wr(OFF_CTRL, 8'h00);
      idle(1);
      check("pin released", {6'h00, cmpOverride, cmpPinOe}, 8'h00);
   endtask : t_force

   task automatic t_ctc();
      restart(8'h00, 8'h03, 8'h19);
      wait_on(1, 1'b1, 12);
      for (int i = 0; i < 4; i++) begin
         reg_rd(OFF_CNT, rd);
         check("clear on match range", {7'h00, rd <= 8'h03}, 8'h01);
      end
      idle(1);
      wait_on(2, ~cmpPinOut, 10);
   endtask : t_ctc

   task automatic t_block();
      logic [7:0] cnt [2] = '{8'h04, 8'h05};
      for (int i = 0; i < 2; i++) begin
         restart(8'h40, 8'h05, 8'h01);
         reg_wr(OFF_CNT, cnt[i]);
         reg_wr(OFF_CTRL, 8'h00);
         idle(2);
         check("match after counter write", {7'h00, cmpMatchFlag}, {7'h00, i == 0});
      end
   endtask : t_block

   task automatic t_normal();
      restart(8'hFD, 8'h00, 8'h01);
      wait_on(0, 1'b1, 8);
      reg_wr(OFF_CTRL, 8'h00);
      reg_rd(OFF_CNT, rd);
      check("wrap to zero", {7'h00, rd < 8'h08}, 8'h01);
      reg_wr(OFF_FLAGS, 8'h01);
      idle(1);
      check("overflow cleared", {7'h00, overflowFlag}, 8'h00);
   endtask : t_normal

   task automatic t_phase();
      int lows;
      restart(8'hFC, 8'h10, 8'h61);
      idle(8);
      check("no overflow at max", {7'h00, overflowFlag}, 8'h00);
      reg_rd(OFF_CNT, rd);
      reg_rd(OFF_CNT, rdB);
      check("counting down", {7'h00, rdB < rd}, 8'h01);
      wait_on(2, 1'b1, 300);
      wait_on(0, 1'b1, 40);
      wait_on(2, 1'b0, 40);
      lows = 0;
      restart(8'hFC, 8'hFF, 8'h61);
      wait_on(2, 1'b1, 10);
      for (int i = 0; i < 520; i++) begin
         idle(1);
         lows += (cmpPinOut !== 1'b1);
      end
      check("compare at top held", {7'h00, lows != 0}, 8'h00);
   endtask : t_phase

   task automatic t_fast();
      logic [7:0] ctl [2] = '{8'h69, 8'h79};
      logic       top [2] = '{1'b1, 1'b0};
      for (int i = 0; i < 2; i++) begin
         restart(8'hF0, 8'h80, ctl[i]);
         wait_on(0, 1'b1, 24);
         check("pin at top", {7'h00, cmpPinOut}, {7'h00, top[i]});
         reg_rd(OFF_CNT, rd);
         check("fast wrap", {7'h00, rd < 8'h08}, 8'h01);
         wait_on(2, ~top[i], 144);
      end
   endtask : t_fast

   task automatic t_prescale();
      int dv [6] = '{8, 32, 64, 128, 256, 1024};
      for (int k = 0; k < 6; k++) begin
         reg_wr(OFF_CTRL, 8'h00);
         reg_wr(OFF_CNT, 8'h00);
         reg_wr(OFF_CTRL, 8'(k + 2));
         idle(4 * dv[k]);
         reg_wr(OFF_CTRL, 8'h00);
         reg_rd(OFF_CNT, rd);
         check("divided count", {7'h00, rd >= 8'h03 && rd <= 8'h05}, 8'h01);
      end
      idle(20);
      reg_rd(OFF_CNT, rdB);
      check("stopped count", rdB, rd);
   endtask : t_prescale

   task automatic t_async();
      restart(8'h00, 8'h80, 8'h01);
      reg_wr(OFF_CFG, 8'h03);
      reg_wr(OFF_CNT, 8'h00);
      idle(10);
      reg_rd(OFF_CNT, rd);
      check("async idle", rd, 8'h00);
      for (int i = 0; i < 5; i++) begin
         oscPin <= 1'b1;
         idle(4);
         oscPin <= 1'b0;
         idle(4);
      end
      idle(4);
      reg_rd(OFF_CNT, rd);
      check("async edges", rd, 8'h05);
      reg_wr(OFF_CFG, 8'h01);
   endtask : t_async

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      reset_n   = 1'b0;
      regAddr   = 3'h0;
      regWrData = 8'h00;
      regWr     = 1'b0;
      regRd     = 1'b0;
      oscPin    = 1'b0;
      repeat (4) @(posedge clk_sys);
      check("outputs in reset", {3'h0, watch, cmpPinOe, cmpOverride}, 8'h00);
      reset_n <= 1'b1;
      t_regs();
      t_force();
      t_ctc();
      t_block();
      t_normal();
      t_phase();
      t_fast();
      t_prescale();
      t_async();
      wrap_up();
   end

endmodule : tb_timer2_waveform_control
